// ===== src/tcc_pkg.sv
// Package with constants and types for the timer channel
package tcc_pkg;
  localparam logic [2:0]  PRESCALE_DIV1     = 3'h0;
  localparam logic [1:0]  EDGE_RISING       = 2'h0;
  localparam logic [2:0]  CLEAR_ON_REG_B    = 3'h2;
  localparam logic [3:0]  PIN_TOGGLE_LOW    = 4'h3;
  localparam logic [3:0]  PIN_CAPTURE_BOTH  = 4'hA;
  localparam logic [3:0]  MODE_NORMAL       = 4'h0;
  localparam logic [7:0]  SRC_REG_B_EVENT   = 8'h16;
  localparam logic [7:0]  SRC_OVERFLOW      = 8'h19;
  localparam logic [15:0] PROTECT_KEY_OPEN  = 16'hA502;
  localparam logic [15:0] PROTECT_KEY_CLOSE = 16'hA500;
  localparam logic [15:0] COUNTER_RST       = 16'h0000;
  localparam logic [15:0] REG_B_RST         = 16'h0000;
  localparam logic        STOP_RST          = 1'b1;
  localparam logic        PIN_LEVEL_RST     = 1'b0;
  localparam logic [15:0] COUNTER_MAX       = 16'hFFFF;

  typedef struct packed {
    logic [2:0] prescale_select;
    logic [2:0] prescale_select_ext;
    logic [1:0] count_edge_select;
    logic [2:0] counter_clear_select;
    logic [3:0] pin_control_reg_b;
    logic [3:0] channel_mode_field;
    logic       reg_b_buffer_select;
    logic       sync_operation_bit;
    logic       pin_output_enable;
    logic       reg_b_irq_enable;
    logic       overflow_irq_enable;
  } tcc_cfg_t;

  typedef struct packed {
    logic [15:0] key;
    logic        key_wr;
    logic        stop_value;
    logic        stop_wr;
  } tcc_stop_req_t;

  typedef struct packed {
    logic reg_b_event_request;
    logic overflow_request;
    logic vector_210_request;
    logic vector_211_request;
  } tcc_req_t;
endpackage

// ===== src/tcc_timer_channel.sv
// Single 16-bit timer channel with toggle compare and both-edge capture on register B
`timescale 1ns/1ps
`default_nettype none

module tcc_timer_channel (
  input  wire logic                   clk_i,                 // 250 MHz clock
  input  wire logic                   rst_b_i,               // Async reset, active low
  input  wire tcc_pkg::tcc_cfg_t      cfg_i,                 // Channel configuration
  input  wire tcc_pkg::tcc_stop_req_t stop_req_i,            // Protect key and stop bit writes
  input  wire logic                   reg_write_enable_i,    // Register write access enable
  input  wire logic                   count_start_bit_i,     // Count start
  input  wire logic                   counter_wr_i,          // Counter write strobe
  input  wire logic [15:0]            counter_wdata_i,       // Counter write data
  input  wire logic                   reg_b_wr_i,            // Register B write strobe
  input  wire logic [15:0]            reg_b_wdata_i,         // Register B write data
  input  wire logic [7:0]             sel_210_i,             // Vector 210 source selector
  input  wire logic [7:0]             sel_211_i,             // Vector 211 source selector
  input  wire logic                   timer_pin_b_i,         // Pin input level
  output logic                        timer_pin_b_o,         // Pin output level
  output logic                        timer_pin_b_oe_o,      // Pin output enable
  output logic                        timer_module_stop_o,   // Module stop state
  output logic [15:0]                 channel_counter_o,     // Counter value
  output logic [15:0]                 general_reg_b_o,       // Register B value
  output tcc_pkg::tcc_req_t           req_o                  // Request pulses
);
  import tcc_pkg::*;

  // ----------------------------------------
  // Module stop and protection
  // ----------------------------------------
  logic protect_open_ff, nxt_protect_open;
  logic stop_ff, nxt_stop;

  always_comb begin
    nxt_protect_open = protect_open_ff;
    nxt_stop         = stop_ff;
    // Key values other than the open and close keys leave protection as it is
    if (stop_req_i.key_wr) begin
      if (stop_req_i.key == PROTECT_KEY_OPEN) begin
        nxt_protect_open = 1'b1;
      end else if (stop_req_i.key == PROTECT_KEY_CLOSE) begin
        nxt_protect_open = 1'b0;
      end
    end
    // Stop bit only changes while protection is open
    if (stop_req_i.stop_wr && protect_open_ff) begin
      nxt_stop = stop_req_i.stop_value;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      protect_open_ff <= 1'b0;
      stop_ff         <= STOP_RST;
    end else begin
      protect_open_ff <= nxt_protect_open;
      stop_ff         <= nxt_stop;
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic count_clk_ok;
  logic toggle_mode;
  logic capture_mode;
  logic clear_on_b;
  logic run;
  logic cfg_wr_ok;

  // Only the undivided rising-edge clock and direct normal mode count here
  assign count_clk_ok = (cfg_i.prescale_select == PRESCALE_DIV1)
                     && (cfg_i.prescale_select_ext == PRESCALE_DIV1)
                     && (cfg_i.count_edge_select == EDGE_RISING)
                     && (cfg_i.channel_mode_field == MODE_NORMAL)
                     && !cfg_i.reg_b_buffer_select
                     && !cfg_i.sync_operation_bit;
  // Other pin control codes keep the pin low and capture off
  assign toggle_mode  = (cfg_i.pin_control_reg_b == PIN_TOGGLE_LOW);
  assign capture_mode = (cfg_i.pin_control_reg_b == PIN_CAPTURE_BOTH);
  assign clear_on_b   = (cfg_i.counter_clear_select == CLEAR_ON_REG_B);
  // A stopped module neither counts nor accepts counter or register B writes
  assign run          = count_start_bit_i && !stop_ff && count_clk_ok;
  assign cfg_wr_ok    = reg_write_enable_i && !stop_ff;

  // ----------------------------------------
  // Pin edge detection
  // ----------------------------------------
  logic pin_prev_ff, nxt_pin_prev;
  logic pin_seen_ff, nxt_pin_seen;
  logic pin_edge;

  // No edge until one real sample is held, so a pin idling high gives no false edge after reset
  assign nxt_pin_prev = timer_pin_b_i;
  assign nxt_pin_seen = 1'b1;
  assign pin_edge     = pin_seen_ff && (pin_prev_ff != timer_pin_b_i);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_prev_ff <= PIN_LEVEL_RST;
      pin_seen_ff <= 1'b0;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
      pin_seen_ff <= nxt_pin_seen;
    end
  end

  // ----------------------------------------
  // Counter, register B and pin output
  // ----------------------------------------
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] reg_b_ff, nxt_reg_b;
  logic        pin_out_ff, nxt_pin_out;
  logic        ev_b_ff, nxt_ev_b;
  logic        ovf_ff, nxt_ovf;
  logic        match;
  logic        capture;

  assign match   = run && toggle_mode && (cnt_ff == reg_b_ff);
  assign capture = run && capture_mode && pin_edge;

  always_comb begin
    nxt_cnt     = cnt_ff;
    nxt_reg_b   = reg_b_ff;
    nxt_pin_out = pin_out_ff;
    nxt_ev_b    = 1'b0;
    nxt_ovf     = 1'b0;
    // Capture beats a software write so no measurement is lost
    if (capture) begin
      nxt_reg_b = cnt_ff;
      nxt_ev_b  = 1'b1;
    end else if (cfg_wr_ok && reg_b_wr_i) begin
      nxt_reg_b = reg_b_wdata_i;
    end
    // Pin is held low outside toggle mode so it starts low on entry
    if (!toggle_mode) begin
      nxt_pin_out = 1'b0;
    end else if (match) begin
      nxt_pin_out = !pin_out_ff;
      nxt_ev_b    = 1'b1;
    end
    if (run) begin
      // Clear on match or capture wins over the wrap, so no overflow then
      if ((match || capture) && clear_on_b) begin
        nxt_cnt = COUNTER_RST;
      end else if (cnt_ff == COUNTER_MAX) begin
        nxt_cnt = COUNTER_RST;
        nxt_ovf = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else if (cfg_wr_ok && counter_wr_i) begin
      nxt_cnt = counter_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff     <= COUNTER_RST;
      reg_b_ff   <= REG_B_RST;
      pin_out_ff <= PIN_LEVEL_RST;
      ev_b_ff    <= 1'b0;
      ovf_ff     <= 1'b0;
    end else begin
      cnt_ff     <= nxt_cnt;
      reg_b_ff   <= nxt_reg_b;
      pin_out_ff <= nxt_pin_out;
      ev_b_ff    <= nxt_ev_b;
      ovf_ff     <= nxt_ovf;
    end
  end

  // ----------------------------------------
  // Outputs and request routing
  // ----------------------------------------
  logic req_b;
  logic req_ovf;

  // Requests follow their enable at once; the event itself lasts one cycle
  assign req_b   = ev_b_ff && cfg_i.reg_b_irq_enable;
  assign req_ovf = ovf_ff && cfg_i.overflow_irq_enable;

  // A stopped module never drives the pin
  assign timer_pin_b_o       = pin_out_ff;
  assign timer_pin_b_oe_o    = cfg_i.pin_output_enable && toggle_mode && !stop_ff;
  assign timer_module_stop_o = stop_ff;
  assign channel_counter_o   = cnt_ff;
  assign general_reg_b_o     = reg_b_ff;

  // Source selector decode shared by both configurable vectors
  function automatic logic route_hit(input logic [7:0] sel,
                                     input logic       ev_b,
                                     input logic       ev_ovf);
    return ((sel == SRC_REG_B_EVENT) && ev_b) || ((sel == SRC_OVERFLOW) && ev_ovf);
  endfunction

  always_comb begin
    req_o.reg_b_event_request = req_b;
    req_o.overflow_request    = req_ovf;
    req_o.vector_210_request  = route_hit(sel_210_i, req_b, req_ovf);
    req_o.vector_211_request  = route_hit(sel_211_i, req_b, req_ovf);
  end
endmodule
`default_nettype wire

// ===== verification/tcc_chk_sva.sv
// Port-level assertion checker for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic              clk_i,               // clk
  input wire logic              rst_b_i,             // rst
  input wire tcc_pkg::tcc_cfg_t cfg_i,               // cfg
  input wire logic              count_start_bit_i,   // run
  input wire logic              counter_wr_i,        // wr
  input wire logic [7:0]        sel_210_i,           // sel
  input wire logic [7:0]        sel_211_i,           // sel
  input wire logic              timer_pin_b_i,       // pin in
  input wire logic              timer_pin_b_o,       // pin out
  input wire logic              timer_pin_b_oe_o,    // oe
  input wire logic              timer_module_stop_o, // stop
  input wire logic [15:0]       channel_counter_o,   // cnt
  input wire logic [15:0]       general_reg_b_o,     // reg b
  input wire tcc_pkg::tcc_req_t req_o                // req
);
  wire tg = cfg_i.pin_control_reg_b == PIN_TOGGLE_LOW;
  wire cp = cfg_i.pin_control_reg_b == PIN_CAPTURE_BOTH;
  wire cl = cfg_i.counter_clear_select == CLEAR_ON_REG_B;
  wire run = count_start_bit_i && !timer_module_stop_o && {cfg_i.prescale_select, cfg_i.prescale_select_ext,
    cfg_i.count_edge_select, cfg_i.channel_mode_field, cfg_i.reg_b_buffer_select, cfg_i.sync_operation_bit} == '0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_count_step: assert property (run && tg && channel_counter_o < general_reg_b_o
    |=> channel_counter_o == $past(channel_counter_o) + 16'h1) else $error("counter did not step");
  chk_hold_idle: assert property (!count_start_bit_i && !counter_wr_i && tg
    |=> $stable(channel_counter_o)) else $error("counter moved while stopped");
  chk_match_clear: assert property (run && tg && cl && channel_counter_o == general_reg_b_o
    |=> channel_counter_o == 16'h0 && timer_pin_b_o != $past(timer_pin_b_o)) else $error("match missed");
  chk_pin_gate: assert property (timer_pin_b_oe_o == (cfg_i.pin_output_enable && tg && !timer_module_stop_o))
    else $error("pin enable wrong");
  chk_toggle_cause: assert property (tg && $past(tg) && $past(run) && timer_pin_b_o != $past(timer_pin_b_o)
    |-> $past(channel_counter_o) == $past(general_reg_b_o)) else $error("toggle without match");
  chk_capture_both: assert property (run && cp && cl && timer_pin_b_i != $past(timer_pin_b_i)
    |=> general_reg_b_o == $past(channel_counter_o) && channel_counter_o == 16'h0) else $error("capture wrong");
  chk_wrap_ovf: assert property (run && channel_counter_o == COUNTER_MAX && general_reg_b_o != COUNTER_MAX
    |=> channel_counter_o == 16'h0 && req_o.overflow_request == cfg_i.overflow_irq_enable) else $error("wrap wrong");
  chk_irq_gate: assert property (!cfg_i.reg_b_irq_enable |-> !req_o.reg_b_event_request)
    else $error("request while disabled");
  chk_vector_route: assert property (req_o.vector_210_request == ((sel_210_i == SRC_REG_B_EVENT
    && req_o.reg_b_event_request) || (sel_210_i == SRC_OVERFLOW && req_o.overflow_request))) else $error("route");
  chk_vector_211: assert property (req_o.vector_211_request == ((sel_211_i == SRC_REG_B_EVENT
    && req_o.reg_b_event_request) || (sel_211_i == SRC_OVERFLOW && req_o.overflow_request))) else $error("route 211");
endmodule
bind tcc_timer_channel tcc_chk u_chk (
  .clk_i               (clk_i),
  .rst_b_i             (rst_b_i),
  .cfg_i               (cfg_i),
  .count_start_bit_i   (count_start_bit_i),
  .counter_wr_i        (counter_wr_i),
  .sel_210_i           (sel_210_i),
  .sel_211_i           (sel_211_i),
  .timer_pin_b_i       (timer_pin_b_i),
  .timer_pin_b_o       (timer_pin_b_o),
  .timer_pin_b_oe_o    (timer_pin_b_oe_o),
  .timer_module_stop_o (timer_module_stop_o),
  .channel_counter_o   (channel_counter_o),
  .general_reg_b_o     (general_reg_b_o),
  .req_o               (req_o)
);
`default_nettype wire

// ===== verification/tcc_pulse_src.sv
// Pulse source driving the timer pin with set high and low widths
`timescale 1ns/1ps
`default_nettype none
module tcc_pulse_src (
  input wire logic       clk_i, // clock
  input wire logic       en_i,  // run
  input wire logic [7:0] hi_i,  // high cycles
  input wire logic [7:0] lo_i,  // low cycles
  output var logic       pin_o  // level
);
  int cnt = 1;
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    if (!en_i) begin
      pin_o <= 1'b0;
      cnt <= 1;
    end else if (cnt >= int'(pin_o ? hi_i : lo_i)) begin
      pin_o <= !pin_o;
      cnt <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/timer_channel_toggle_and_capture_test.sv
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; $display("Error %s exp %0h got %0h", n, e, a); end end
module timer_channel_toggle_and_capture_test;
  import tcc_pkg::*;
  logic clk_i = 0, rst_b_i = 0, reg_write_enable = 0, cs = 0, cwr = 0, bwr = 0, src_en = 0;
  logic pin_i, pin_o, oe, stop_o, src_pin;
  tcc_cfg_t cfg = '0;
  tcc_stop_req_t sreq = '0;
  tcc_req_t req;
  logic [15:0] wd = '0, cnt_o, regb_o;
  logic [7:0] s210 = SRC_REG_B_EVENT, s211 = SRC_OVERFLOW, hi = 8'h4, lo = 8'h4;
  logic [31:0] rs = 32'h44;
  int fail_count = 0, samples_checked = 0, n, k;
  int lvl_q[$];
  int lvl_n = 0, e;
  logic pin_d = 1'b0;
  assign pin_i = oe ? pin_o : src_pin;
  tcc_timer_channel dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg), .stop_req_i(sreq), .reg_write_enable_i(reg_write_enable),
    .count_start_bit_i(cs), .counter_wr_i(cwr), .counter_wdata_i(wd), .reg_b_wr_i(bwr), .reg_b_wdata_i(wd),
    .sel_210_i(s210), .sel_211_i(s211), .timer_pin_b_i(pin_i), .timer_pin_b_o(pin_o), .timer_pin_b_oe_o(oe),
    .timer_module_stop_o(stop_o), .channel_counter_o(cnt_o), .general_reg_b_o(regb_o), .req_o(req));
  tcc_pulse_src src (.clk_i(clk_i), .en_i(src_en), .hi_i(hi), .lo_i(lo), .pin_o(src_pin));
  // Model: each pin level lasting L clocks is expected back as a capture of L - 1
  always @(posedge clk_i) begin
    if (pin_i !== pin_d) begin
      lvl_q.push_back(lvl_n - 1);
      lvl_n = 1;
    end else begin
      lvl_n++;
    end
    pin_d = pin_i;
  end
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic stop_cmd(input logic [15:0] key, input logic kw, input logic sw);
    @(posedge clk_i);
    sreq <= '{key, kw, 1'b0, sw};
    @(posedge clk_i);
    sreq <= '0;
  endtask
  task automatic wr(input logic c, input logic [15:0] d);
    @(posedge clk_i);
    cwr <= c;
    bwr <= !c;
    wd <= d;
    @(posedge clk_i);
    cwr <= 0;
    bwr <= 0;
  endtask
  task automatic gap(output int g);
    logic p;
    p = pin_o;
    g = 0;
    while (pin_o === p && g < 300) begin @(posedge clk_i); #1; g++; end
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1;
    #1;
    `CHK("stop", 1'b1, stop_o)
    stop_cmd(16'h0, 0, 1);
    #1;
    `CHK("stop_closed", 1'b1, stop_o)
    stop_cmd(PROTECT_KEY_OPEN, 1, 0);
    stop_cmd(16'h0, 0, 1);
    #1;
    `CHK("stop_open", 1'b0, stop_o)
    stop_cmd(PROTECT_KEY_CLOSE, 1, 0);
    reg_write_enable <= 1;
    cfg <= '{counter_clear_select: CLEAR_ON_REG_B, pin_control_reg_b: PIN_TOGGLE_LOW, pin_output_enable: 1'b1,
      reg_b_irq_enable: 1'b1, overflow_irq_enable: 1'b1, default: '0};
    rs = xs(rs);
    k = 2 + int'(rs[3:0]);
    wr(0, 16'(k));
    wr(1, COUNTER_MAX);
    reg_write_enable <= 0;
    wr(0, 16'h0);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("hold", COUNTER_MAX, cnt_o)
    `CHK("locked", 16'(k), regb_o)
    @(posedge clk_i);
    cs <= 1;
    @(posedge clk_i);
    #1;
    `CHK("wrap", 16'h0, cnt_o)
    `CHK("ovf", 1'b1, req.overflow_request)
    `CHK("v211", 1'b1, req.vector_211_request)
    `CHK("oe_on", 1'b1, oe)
    gap(n);
    for (int i = 0; i < 4; i++) begin
      gap(n);
      `CHK("half", k + 1, n)
      `CHK("b_req", 1'b1, req.reg_b_event_request)
    end
    @(posedge clk_i);
    {cfg.pin_output_enable, cfg.reg_b_irq_enable} <= 2'b00;
    rs = xs(rs);
    hi = 8'(3 + int'(rs[3:0]));
    lo = 8'(3 + int'(rs[7:4]));
    @(posedge clk_i);
    #1;
    `CHK("oe_off", 1'b0, oe)
    gap(n);
    `CHK("irq_off", 1'b0, req.reg_b_event_request)
    @(posedge clk_i);
    {cfg.pin_control_reg_b, cfg.reg_b_irq_enable} <= {PIN_CAPTURE_BOTH, 1'b1};
    src_en <= 1;
    lvl_q.delete();
    for (int i = 0; i < 6; i++) begin
      n = 0;
      do begin @(posedge clk_i); #1; n++; end while (req.reg_b_event_request !== 1'b1 && n < 100);
      `CHK("v210", 1'b1, req.vector_210_request)
      e = -1;
      if (lvl_q.size() > 0) e = lvl_q.pop_front();
      if (i > 1) `CHK("capture", 16'(int'(pin_i ? lo : hi) - 1), regb_o)
      if (i > 1) `CHK("width_model", 16'(e), regb_o)
    end
    end_of_test;
  end
endmodule
`default_nettype wire
